// ---- hw/terminal_regs_pkg.sv ----
// Register map, field layout and timing constants of the bus terminal register block
package terminal_regs_pkg;

   // Register byte addresses (word aligned)
   localparam logic [4:0] ADDR_CONFIG = 5'h00;
   localparam logic [4:0] ADDR_EXT_BASE = 5'h04;
   localparam logic [4:0] ADDR_CMD_STATE = 5'h08;
   localparam logic [4:0] ADDR_NOMINAL = 5'h0C;
   localparam logic [4:0] ADDR_ERROR = 5'h10;
   localparam logic [4:0] ADDR_RESET_EVT = 5'h14;
   localparam logic [4:0] ADDR_RX_INDEX = 5'h18;
   localparam logic [4:0] ADDR_TX_INDEX = 5'h1C;

   // terminal_config field positions
   localparam int CFG_SHORT_EN = 27;
   localparam int CFG_AREA_HI = 24;
   localparam int CFG_AREA_LO = 16;
   localparam int CFG_ERR_MASK = 15;
   localparam int CFG_SYNC_MASK = 14;
   localparam int CFG_EXCH_MASK = 13;
   localparam int CFG_SUBAD_HI = 12;
   localparam int CFG_SUBAD_LO = 8;
   localparam int CFG_WORD_SIZE = 7;
   localparam int CFG_EXT_AREA = 6;
   localparam int CFG_BCAST = 4;
   localparam int CFG_BUS_CTRL = 3;
   localparam int CFG_TIMEOUT = 2;
   localparam int CFG_MODE_HI = 1;
   localparam int CFG_MODE_LO = 0;

   // command_state_ctrl field positions
   localparam int CMD_LAST_LO = 15;
   localparam int CMD_PARITY = 14;
   localparam int CMD_ACTIVITY = 6;
   localparam int CMD_RUN_STATE = 5;
   localparam int CMD_RUN_CTRL = 1;
   localparam int CMD_TERM_RESET = 0;

   // Event flag positions
   localparam int NOM_SUBAD_LO = 4;
   localparam int NOM_SWITCH = 3;
   localparam int NOM_BUS_CTRL = 2;
   localparam int NOM_SYNC = 1;
   localparam int NOM_EXCH = 0;
   localparam int ERR_ADDR_PAR = 4;
   localparam int ERR_BUS = 1;
   localparam int ERR_MEM = 0;

   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam logic [16:0] LAST_CMD_RESET = 17'h10FFE;
   localparam int AREA_LOW_BITS = 19;

   // Response timeout
   localparam int CLOCK_MHZ = 25;
   localparam int TIMEOUT_SHORT_US = 14;
   localparam int TIMEOUT_LONG_US = 31;
   localparam int TIMEOUT_SHORT_CYCLES = TIMEOUT_SHORT_US * CLOCK_MHZ;
   localparam int TIMEOUT_LONG_CYCLES = TIMEOUT_LONG_US * CLOCK_MHZ;

   typedef enum logic [1:0] {MODE_RT0 = 2'h0, MODE_RES1 = 2'h1, MODE_RES2 = 2'h2,
      MODE_RT3 = 2'h3} term_mode_t;

   // Events reported by the protocol engine, one-cycle pulses
   typedef struct packed {
      logic table_switch;
      logic [4:0] switch_subaddr;
      logic bus_control_cmd;
      logic sync_order;
      logic exchange_done;
      logic address_parity;
      logic bus_error;
      logic memory_error;
      logic reset_cmd;
   } engine_events_t;

   // Settings passed to the protocol engine
   typedef struct packed {
      logic short_word_mode;
      logic [31:0] memory_base;
      logic extended_area_enable;
      logic [4:0] extended_subaddress;
      logic broadcast_enable;
      logic bus_control_enable;
      logic [9:0] timeout_cycles;
      logic rt_mode;
   } engine_config_t;

endpackage : terminal_regs_pkg

// ---- hw/mil_1553_remote_terminal_regs.sv ----
// Avalon-MM register block for a serial-bus remote terminal: config, state and event flags
//
// Contract
// - Word size select gives 16-bit words only while short-word enable set.
// - Memory base is the 9-bit area field above 19 zero address bits.
// - Bus error raises error interrupt only while its mask is zero.
// - Sync and exchange events drive nominal interrupt only while unmasked.
// - Extended area bit enables extended mode for the named sub-address.
// - Broadcast and dynamic bus control honoured only when their bits set.
// - Response timeout is 14 us when select is 0, 31 us when 1.
// - Mode codes 0 and 3 mean remote terminal; 1 and 2 reserved.
// - Extended area base is read-only, loaded from the bus side.
// - Last command address reads back, resetting to an out-of-area value.
// - Run state bit is 0 in reset or init, 1 once running.
// - Writing 1 to run control starts the terminal function in modes 0 and 3, unless terminal reset is written 1 in the same write.
// - Writing 1 to terminal reset resets the terminal part.
// - Table switch flag records sub-address, clears on register read.
// - Bus control command flag sets on command, clears on read.
// - Sync flag sets on synchronise order, clears on read.
// - Exchange done flag sets after valid exchange, clears on read.
// - Address parity error sets clear-on-read flag and sticky status bit.
// - Bus error and memory error flags clear on error register read.
// - Reset command flag sets on valid reset command, clears on read.
// - Interrupt outputs go to the controller; cleared only inside this block.
`timescale 1ns/100ps
module mil_1553_remote_terminal_regs
   import terminal_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire engine_events_t events,
   input wire logic ext_base_load,
   input wire logic [25:0] ext_base_value,
   input wire logic cmd_addr_load,
   input wire logic [16:0] cmd_addr_value,
   input wire logic engine_busy,
   input wire logic engine_ready,
   input wire logic [31:0] rx_index_in,
   input wire logic [31:0] tx_index_in,
   output engine_config_t engine_cfg,
   output logic engine_run,
   output logic engine_reset,
   output logic nominal_irq_out,
   output logic error_irq_out,
   output logic reset_irq_out
);

   logic [31:0] terminal_config;
   logic [25:0] extended_area_address;
   logic [16:0] last_command_address;
   logic address_parity_status;
   logic run_control;
   logic terminal_reset;
   logic cmd_spare;
   logic activity_flag;
   logic run_state;
   logic [4:0] switched_subaddress;
   logic table_switch_flag;
   logic bus_control_flag;
   logic sync_flag;
   logic exchange_done_flag;
   logic address_parity_flag;
   logic bus_error_flag;
   logic memory_error_flag;
   logic terminal_reset_cmd_flag;
   logic [31:0] receive_index_value;
   logic [31:0] transmit_index_value;
   logic access_done;

   // Merge a write into a word under byte enables
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
      input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            res[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return res;
   endfunction : merge_bytes

   // Set wins over a clearing read in the same cycle so a coincident event is not lost
   function automatic logic sticky_flag(input logic flag, input logic hit, input logic clr);
      return hit | (flag & ~clr);
   endfunction : sticky_flag

   // One wait cycle for every access keeps read data registered
   wire logic req = (avs_read | avs_write) & ~access_done;
   wire logic wr_cfg = req & avs_write & (avs_address == ADDR_CONFIG);
   wire logic wr_cmd = req & avs_write & (avs_address == ADDR_CMD_STATE);
   wire logic rd_nom = req & avs_read & (avs_address == ADDR_NOMINAL);
   wire logic rd_err = req & avs_read & (avs_address == ADDR_ERROR);
   wire logic rd_rst = req & avs_read & (avs_address == ADDR_RESET_EVT);
   wire logic [31:0] cfg_merged = merge_bytes(terminal_config, avs_writedata, avs_byteenable);
   wire logic [31:0] cmd_merged = merge_bytes(32'h0000_0000, avs_writedata, avs_byteenable);
   wire logic short_mode = terminal_config[CFG_SHORT_EN] & terminal_config[CFG_WORD_SIZE];
   wire logic [1:0] mode_code = terminal_config[CFG_MODE_HI:CFG_MODE_LO];
   wire logic rt_mode = (mode_code == MODE_RT0) | (mode_code == MODE_RT3);
   wire logic [9:0] timeout_sel = terminal_config[CFG_TIMEOUT] ? 10'(TIMEOUT_LONG_CYCLES)
      : 10'(TIMEOUT_SHORT_CYCLES);
   // The engine's timeout field is ten bits wide; a faster clock needs a wider field
   if (TIMEOUT_LONG_CYCLES >= 2 ** $bits(timeout_sel))
   begin : g_timeout_fits
      $error("long response timeout does not fit the engine field");
   end
   wire logic [31:0] mem_base = {4'h0, terminal_config[CFG_AREA_HI:CFG_AREA_LO],
      {AREA_LOW_BITS{1'b0}}};
   wire logic nominal_pending = table_switch_flag | (bus_control_flag & rt_mode)
      | (sync_flag & ~terminal_config[CFG_SYNC_MASK])
      | (exchange_done_flag & ~terminal_config[CFG_EXCH_MASK]);
   wire logic error_pending = address_parity_flag | memory_error_flag
      | (bus_error_flag & ~terminal_config[CFG_ERR_MASK]);

   // Read words, assembled field by field from the register contents
   wire logic [31:0] ext_word = {6'h00, extended_area_address};
   wire logic [31:0] cmd_word = {last_command_address, address_parity_status, 7'h00,
      activity_flag, run_state, 2'h0, cmd_spare, run_control, terminal_reset};
   wire logic [31:0] nom_word = {23'h0, switched_subaddress, table_switch_flag, bus_control_flag,
      sync_flag, exchange_done_flag};
   wire logic [31:0] err_word = {27'h0, address_parity_flag, 2'h0, bus_error_flag,
      memory_error_flag};
   wire logic [31:0] rst_word = {31'h0, terminal_reset_cmd_flag};

   logic [31:0] read_mux;
   always_comb
   begin
      read_mux = 32'h0000_0000;
      case (avs_address)
         ADDR_CONFIG: read_mux = terminal_config;
         ADDR_EXT_BASE: read_mux = ext_word;
         ADDR_CMD_STATE: read_mux = cmd_word;
         ADDR_NOMINAL: read_mux = nom_word;
         ADDR_ERROR: read_mux = err_word;
         ADDR_RESET_EVT: read_mux = rst_word;
         ADDR_RX_INDEX: read_mux = receive_index_value;
         ADDR_TX_INDEX: read_mux = transmit_index_value;
         default: read_mux = 32'h0000_0000;
      endcase
   end

   // Next flag values; each flag clears on a read of its own register
   wire logic next_table_switch_flag = sticky_flag(table_switch_flag,
      events.table_switch, rd_nom);
   wire logic next_bus_control_flag = sticky_flag(bus_control_flag,
      events.bus_control_cmd & rt_mode & terminal_config[CFG_BUS_CTRL], rd_nom);
   wire logic next_sync_flag = sticky_flag(sync_flag, events.sync_order, rd_nom);
   wire logic next_exchange_done_flag = sticky_flag(exchange_done_flag,
      events.exchange_done, rd_nom);
   wire logic next_address_parity_flag = sticky_flag(address_parity_flag,
      events.address_parity, rd_err);
   wire logic next_bus_error_flag = sticky_flag(bus_error_flag,
      events.bus_error, rd_err);
   wire logic next_memory_error_flag = sticky_flag(memory_error_flag,
      events.memory_error, rd_err);
   wire logic next_terminal_reset_cmd_flag = sticky_flag(terminal_reset_cmd_flag,
      events.reset_cmd, rd_rst);

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         access_done <= 1'b0;
         avs_waitrequest <= 1'b1;
      end
      else
      begin
         access_done <= req;
         avs_waitrequest <= ~req;
      end
   end

   // Read data is captured as the access is taken and then holds until the next read
   always_ff @(posedge mclk)
   begin
      if (reset)
         avs_readdata <= 32'h0000_0000;
      else if (req & avs_read)
         avs_readdata <= read_mux;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         terminal_config <= CONFIG_RESET;
      else if (wr_cfg)
         terminal_config <= cfg_merged;
   end

   // Run and reset controls; run is dropped while the terminal part is held in reset
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         run_control <= 1'b0;
         terminal_reset <= 1'b0;
         cmd_spare <= 1'b0;
      end
      else if (wr_cmd)
      begin
         run_control <= cmd_merged[CMD_RUN_CTRL] & ~cmd_merged[CMD_TERM_RESET];
         terminal_reset <= cmd_merged[CMD_TERM_RESET];
         cmd_spare <= cmd_merged[2];
      end
   end

   // The terminal reset bit clears everything the bus side has reported except the receive and transmit index words
   always_ff @(posedge mclk)
   begin
      if (reset | terminal_reset)
         extended_area_address <= 26'h0;
      else if (ext_base_load)
         extended_area_address <= ext_base_value;
   end

   always_ff @(posedge mclk)
   begin
      if (reset | terminal_reset)
         last_command_address <= LAST_CMD_RESET;
      else if (cmd_addr_load)
         last_command_address <= cmd_addr_value;
   end

   // Parity status is sticky: only a reset clears it, unlike its clear-on-read twin
   always_ff @(posedge mclk)
   begin
      if (reset | terminal_reset)
         address_parity_status <= 1'b0;
      else if (events.address_parity)
         address_parity_status <= 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (reset | terminal_reset)
      begin
         run_state <= 1'b0;
         activity_flag <= 1'b0;
      end
      else
      begin
         run_state <= run_control & engine_ready;
         activity_flag <= run_control & engine_ready & engine_busy;
      end
   end

   // Sub-address of the last table switch; it survives the read that clears the flag
   always_ff @(posedge mclk)
   begin
      if (reset | terminal_reset)
         switched_subaddress <= 5'h00;
      else if (events.table_switch)
         switched_subaddress <= events.switch_subaddr;
   end

   always_ff @(posedge mclk)
   begin
      if (reset | terminal_reset)
      begin
         table_switch_flag <= 1'b0;
         bus_control_flag <= 1'b0;
         sync_flag <= 1'b0;
         exchange_done_flag <= 1'b0;
      end
      else
      begin
         table_switch_flag <= next_table_switch_flag;
         bus_control_flag <= next_bus_control_flag;
         sync_flag <= next_sync_flag;
         exchange_done_flag <= next_exchange_done_flag;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset | terminal_reset)
      begin
         address_parity_flag <= 1'b0;
         bus_error_flag <= 1'b0;
         memory_error_flag <= 1'b0;
      end
      else
      begin
         address_parity_flag <= next_address_parity_flag;
         bus_error_flag <= next_bus_error_flag;
         memory_error_flag <= next_memory_error_flag;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset | terminal_reset)
         terminal_reset_cmd_flag <= 1'b0;
      else
         terminal_reset_cmd_flag <= next_terminal_reset_cmd_flag;
   end

   // Interrupt lines follow the flags; the external controller cannot clear them
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         nominal_irq_out <= 1'b0;
         error_irq_out <= 1'b0;
         reset_irq_out <= 1'b0;
      end
      else
      begin
         nominal_irq_out <= nominal_pending;
         error_irq_out <= error_pending;
         reset_irq_out <= terminal_reset_cmd_flag;
      end
   end

   // Index words are registered so a read never catches a value in mid-change
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         receive_index_value <= 32'h0;
         transmit_index_value <= 32'h0;
      end
      else
      begin
         receive_index_value <= rx_index_in;
         transmit_index_value <= tx_index_in;
      end
   end

   // Engine settings are registered, so they follow a config write one cycle later
   always_ff @(posedge mclk)
   begin
      if (reset)
         engine_cfg <= '0;
      else
      begin
         engine_cfg.short_word_mode <= short_mode;
         engine_cfg.memory_base <= mem_base;
         engine_cfg.extended_area_enable <= terminal_config[CFG_EXT_AREA];
         engine_cfg.extended_subaddress <= terminal_config[CFG_SUBAD_HI:CFG_SUBAD_LO];
         engine_cfg.broadcast_enable <= terminal_config[CFG_BCAST];
         engine_cfg.bus_control_enable <= terminal_config[CFG_BUS_CTRL];
         engine_cfg.timeout_cycles <= timeout_sel;
         engine_cfg.rt_mode <= rt_mode;
      end
   end

   // Run is withheld in the reserved modes so a bad mode code cannot start the engine
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         engine_run <= 1'b0;
         engine_reset <= 1'b1;
      end
      else
      begin
         engine_run <= run_control & rt_mode;
         engine_reset <= terminal_reset;
      end
   end

endmodule : mil_1553_remote_terminal_regs

// ---- verif/terminal_regs_props.sv ----
// Concurrent checks on the terminal register block ports
`timescale 1ns/100ps
module terminal_regs_props
   import terminal_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire engine_events_t events,
   input wire engine_config_t engine_cfg,
   input wire logic engine_reset,
   input wire logic nominal_irq_out,
   input wire logic error_irq_out,
   input wire logic reset_irq_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   // Terminal reset clears flags, so irq checks need it low for two edges
   sequence s_live;
      !engine_reset ##1 !engine_reset;
   endsequence
   property p_answer; s_req |=> !avs_waitrequest; endproperty
   property p_one; s_req ##1 !avs_waitrequest |=> avs_waitrequest; endproperty
   property p_rst_irq; events.reset_cmd ##0 s_live |=> reset_irq_out; endproperty
   property p_par_irq; events.address_parity ##0 s_live |=> error_irq_out; endproperty
   property p_mem_irq; events.memory_error ##0 s_live |=> error_irq_out; endproperty
   property p_sw_irq; events.table_switch ##0 s_live |=> nominal_irq_out; endproperty
   property p_base;
      engine_cfg.memory_base[18:0] == 19'h0 && engine_cfg.memory_base[31:28] == 4'h0;
   endproperty
   property p_tmo;
      !$past(reset) |-> (engine_cfg.timeout_cycles == TIMEOUT_SHORT_CYCLES ||
         engine_cfg.timeout_cycles == TIMEOUT_LONG_CYCLES);
   endproperty
   property p_rel;
      $fell(reset) |-> avs_waitrequest && engine_reset && !nominal_irq_out && !error_irq_out
         && !reset_irq_out;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after request");
   a_one: assert property (p_one) else $error("wait low too long");
   a_rst_irq: assert property (p_rst_irq) else $error("reset irq missing");
   a_par_irq: assert property (p_par_irq) else $error("parity irq missing");
   a_mem_irq: assert property (p_mem_irq) else $error("memory irq missing");
   a_sw_irq: assert property (p_sw_irq) else $error("switch irq missing");
   a_base: assert property (p_base) else $error("memory base low bits set");
   a_tmo: assert property (p_tmo) else $error("bad timeout count");
   a_rel: assert property (p_rel) else $error("bad values after reset");
endmodule : terminal_regs_props

// ---- verif/engine_model.sv ----
// Behavioural protocol engine driving events, loads and indices
`timescale 1ns/100ps
module engine_model
   import terminal_regs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic engine_run,
   input wire logic engine_reset,
   input wire logic fire,
   input wire engine_events_t fire_ev,
   input wire logic fire_ld,
   input wire logic [25:0] ld_val,
   output engine_events_t events,
   output logic ext_base_load,
   output logic [25:0] ext_base_value,
   output logic cmd_addr_load,
   output logic [16:0] cmd_addr_value,
   output logic engine_busy,
   output logic engine_ready,
   output logic [31:0] rx_index_in,
   output logic [31:0] tx_index_in
);
   logic ready_q;
   always_ff @(posedge mclk)
   begin
      // Two-stage start so ready lags the run request
      ready_q <= engine_run & ~engine_reset & ~reset;
      engine_ready <= ready_q & engine_run & ~engine_reset;
      engine_busy <= ready_q;
      events <= fire ? fire_ev : '0;
      ext_base_load <= fire & fire_ld;
      cmd_addr_load <= fire & fire_ld;
      ext_base_value <= fire ? ld_val : ~ext_base_value;
      cmd_addr_value <= fire ? ld_val[16:0] : ~cmd_addr_value;
      if (reset)
      begin
         rx_index_in <= 32'h0;
         tx_index_in <= 32'h0;
      end
      else
      begin
         rx_index_in <= rx_index_in + 32'(events.exchange_done);
         tx_index_in <= tx_index_in + 32'(events.table_switch);
      end
   end
endmodule : engine_model

// ---- verif/mil_1553_remote_terminal_regs_tb.sv ----
// Self-checking bench for the terminal register block
`timescale 1ns/100ps
module mil_1553_remote_terminal_regs_tb
   import terminal_regs_pkg::*;
;
   logic mclk = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rx_index_in, tx_index_in, x = 32'h3A, q;
   logic ext_base_load, cmd_addr_load, engine_busy, engine_ready, engine_run, engine_reset;
   logic nominal_irq_out, error_irq_out, reset_irq_out, fire = 0, fire_ld = 0;
   logic [25:0] ext_base_value, ld_val = 26'h0;
   logic [16:0] cmd_addr_value;
   engine_events_t events, fire_ev = '0, e;
   engine_config_t engine_cfg;
   int errors = 0, num_checks = 0;
   initial forever #20 mclk = ~mclk;
   mil_1553_remote_terminal_regs mil_1553_remote_terminal_regs_inst (.mclk(mclk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .events(events), .ext_base_load(ext_base_load),
      .ext_base_value(ext_base_value), .cmd_addr_load(cmd_addr_load),
      .cmd_addr_value(cmd_addr_value), .engine_busy(engine_busy), .engine_ready(engine_ready),
      .rx_index_in(rx_index_in), .tx_index_in(tx_index_in), .engine_cfg(engine_cfg),
      .engine_run(engine_run), .engine_reset(engine_reset), .nominal_irq_out(nominal_irq_out),
      .error_irq_out(error_irq_out), .reset_irq_out(reset_irq_out));
   engine_model engine_model_inst (.mclk(mclk), .reset(reset), .engine_run(engine_run),
      .engine_reset(engine_reset), .fire(fire), .fire_ev(fire_ev), .fire_ld(fire_ld),
      .ld_val(ld_val), .events(events), .ext_base_load(ext_base_load),
      .ext_base_value(ext_base_value), .cmd_addr_load(cmd_addr_load),
      .cmd_addr_value(cmd_addr_value), .engine_busy(engine_busy), .engine_ready(engine_ready),
      .rx_index_in(rx_index_in), .tx_index_in(tx_index_in));
   function automatic logic [31:0] rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : rnd
   function automatic engine_config_t exp_cfg(logic [31:0] c);
      return '{c[27] & c[7], {4'h0, c[24:16], 19'h0}, c[6], c[12:8], c[4], c[3],
         c[2] ? 10'(TIMEOUT_LONG_CYCLES) : 10'(TIMEOUT_SHORT_CYCLES),
         c[1:0] == 2'h0 || c[1:0] == 2'h3};
   endfunction : exp_cfg
   task automatic chk(logic [63:0] got, logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
      @(posedge mclk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      if (!wr)
         q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
   endtask : bus
   task automatic rd(logic [4:0] a, logic [31:0] exp);
      bus(0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   task automatic ev(engine_events_t v, logic ld);
      @(posedge mclk);
      fire <= 1;
      fire_ev <= v;
      fire_ld <= ld;
      @(posedge mclk);
      fire <= 0;
      repeat (4) @(posedge mclk);
   endtask : ev
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (20000) @(posedge mclk);
      errors++;
      wrap_up();
   end
   initial
   begin
      repeat (16) @(posedge mclk);
      reset <= 0;
      for (int a = 0; a < 8; a++)
         rd(5'(a * 4), a == 2 ? 32'h87FF0000 : 32'h0);
      $display("reset values done");
      for (int i = 0; i < 12; i++)
      begin
         q = i < 4 ? 32'h0880E07C | 32'(i) : rnd();
         bus(1, ADDR_CONFIG, q);
         repeat (2) @(posedge mclk);
         chk(engine_cfg, exp_cfg(q));
         rd(ADDR_CONFIG, q);
      end
      $display("config done");
      bus(1, ADDR_CONFIG, 32'h00000008);
      for (int i = 0; i < 8; i++)
      begin
         e = engine_events_t'(i == 7 ? 13'h1A80 : 13'h1 << i);
         ev(e, 0);
         chk(nominal_irq_out, |{e.table_switch, e.bus_control_cmd, e.sync_order,
            e.exchange_done});
         chk(error_irq_out, |{e.address_parity, e.bus_error, e.memory_error});
         chk(reset_irq_out, e.reset_cmd);
         rd(ADDR_NOMINAL, {23'h0, i >= 7 ? 5'h15 : 5'h0, e.table_switch, e.bus_control_cmd,
            e.sync_order, e.exchange_done});
         rd(ADDR_ERROR, {27'h0, e.address_parity, 2'h0, e.bus_error, e.memory_error});
         rd(ADDR_RESET_EVT, {31'h0, e.reset_cmd});
         rd(ADDR_NOMINAL, i >= 7 ? 32'h150 : 32'h0);
      end
      $display("event flags done");
      bus(1, ADDR_CONFIG, 32'h0000E008);
      ev('{0, 5'h0, 0, 1, 1, 0, 1, 0, 0}, 1);
      chk({nominal_irq_out, error_irq_out}, 2'b00);
      rd(ADDR_NOMINAL, 32'h153);
      ld_val <= 26'h2ABCDEF;
      bus(1, ADDR_EXT_BASE, 32'hFFFFFFFF);
      ev('{0, 5'h0, 0, 0, 0, 1, 0, 0, 0}, 1);
      chk(error_irq_out, 1'b1);
      rd(ADDR_EXT_BASE, 32'h02ABCDEF);
      bus(1, ADDR_CMD_STATE, 32'h2);
      repeat (6) @(posedge mclk);
      rd(ADDR_CMD_STATE, 32'hE6F78000 | 32'h4062);
      rd(ADDR_RX_INDEX, 32'h2);
      rd(ADDR_TX_INDEX, 32'h1);
      bus(1, ADDR_CMD_STATE, 32'h1);
      repeat (3) @(posedge mclk);
      chk(engine_reset, 1'b1);
      rd(ADDR_CMD_STATE, 32'h87FF0001);
      bus(1, ADDR_CMD_STATE, 32'h0);
      $display("run and reset done");
      wrap_up();
   end
endmodule : mil_1553_remote_terminal_regs_tb
bind mil_1553_remote_terminal_regs terminal_regs_props terminal_regs_props_inst (.mclk(mclk),
   .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .events(events), .engine_cfg(engine_cfg),
   .engine_reset(engine_reset), .nominal_irq_out(nominal_irq_out),
   .error_irq_out(error_irq_out), .reset_irq_out(reset_irq_out));
